/* accessory_switch_control_regs.sv */
// Purpose: Control, delay and mode registers of the accessory switch.
// Assumes: Host reaches registers over the serial link module.
// Notes:   Soft reset returns all host state to reset values.
`timescale 1ns/10ps
`include "switch_ctrl_params.svh"

module accessory_switch_control_regs
#(
  parameter logic [31:0] IDENT_STEP_CYCLES = `IDENT_STEP_MS * `CLK_KHZ,
  parameter logic [31:0] IDLE_STEP_CYCLES = `IDLE_STEP_S * `CLK_KHZ * 1000
)
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // Serial link
  input wire logic LINK_CLK_IN,
  input wire logic LINK_SEL_N_IN,
  input wire logic LINK_DATA_IN,
  output logic LINK_DATA_OUT,
  output logic LINK_DATA_OE_OUT,
  // Pins from the analog side
  input wire logic BUS_VOLTAGE_IN,
  input wire logic SWITCH_ACTIVITY_IN,
  input wire logic AUDIO_OR_TTY_ATTACHED_IN,
  input wire logic POWER_SWITCH_SENSE_IN,
  // Controls to the analog side
  output logic POWER_SWITCH_ON_OUT,
  output logic LEFT_SPEAKER_TO_MINUS_SWITCH_OUT,
  output logic LOW_POWER_STATE_OUT,
  output logic ACTIVE_MODE_OUT,
  output logic IDENT_START_OUT
);

  // ************************************************************
  // Link and crossings
  // ************************************************************
  switch_ctrl_pkg::reg_access_t link_req;
  logic link_toggle;
  logic tgl_s1, tgl_s2, tgl_seen, next_tgl_seen;
  logic ack_toggle, next_ack_toggle;
  logic [7:0] rdata, next_rdata;
  logic [3:0] pin_s1, pin_s2;
  logic bus_s, activity_s, attached_s, sense_s;

  serial_reg_link link_u
  (
    .link_clk_in(LINK_CLK_IN),
    .reset_n_in(RESET_N_IN),
    .sel_n_in(LINK_SEL_N_IN),
    .data_in(LINK_DATA_IN),
    .data_out(LINK_DATA_OUT),
    .data_oe_out(LINK_DATA_OE_OUT),
    .req_out(link_req),
    .req_toggle_out(link_toggle),
    .ack_toggle_in(ack_toggle),
    .rdata_in(rdata)
  );

  // Two-stage synchronisers for pins and the link toggle
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
    end
    else
    begin
      pin_s1 <= {POWER_SWITCH_SENSE_IN, AUDIO_OR_TTY_ATTACHED_IN,
                 SWITCH_ACTIVITY_IN, BUS_VOLTAGE_IN};
      pin_s2 <= pin_s1;
      tgl_s1 <= link_toggle;
      tgl_s2 <= tgl_s1;
    end
  end

  assign bus_s = pin_s2[0];
  assign activity_s = pin_s2[1];
  assign attached_s = pin_s2[2];
  assign sense_s = pin_s2[3];

  // Access decode; payload is quiet for two cycles before the toggle
  logic access, wr, rd, in_test;
  assign access = tgl_s2 != tgl_seen;
  assign wr = access & link_req.write;
  assign rd = access & ~link_req.write;
  assign in_test = link_req.addr >= `ADDR_TEST_FIRST &&
                   link_req.addr <= `ADDR_TEST_LAST;

  // ************************************************************
  // Delay timers: 0 identification delay, 1 idle detection
  // ************************************************************
  logic [1:0] tmr_clear, tmr_start, tmr_armed, tmr_done;
  logic [3:0] tmr_code [2];
  logic [31:0] tmr_step_cycles [2];
  assign tmr_step_cycles[0] = IDENT_STEP_CYCLES;
  assign tmr_step_cycles[1] = IDLE_STEP_CYCLES;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : tmr_g
      logic [31:0] step, next_step;
      logic [3:0] units, next_units;
      logic armed, next_armed;

      // Counts (code + 1) whole steps, then pulses done
      always_comb
      begin
        next_step = step;
        next_units = units;
        next_armed = armed;
        tmr_done[g] = 1'b0;
        if (tmr_clear[g])
        begin
          next_armed = 1'b0;
        end
        else if (tmr_start[g])
        begin
          next_armed = 1'b1;
          next_step = 32'h0;
          next_units = 4'h0;
        end
        else if (armed)
        begin
          if (step == tmr_step_cycles[g] - 32'h1)
          begin
            next_step = 32'h0;
            if (units == tmr_code[g])
            begin
              tmr_done[g] = 1'b1;
              next_armed = 1'b0;
            end
            else
            begin
              next_units = units + 4'h1;
            end
          end
          else
          begin
            next_step = step + 32'h1;
          end
        end
      end

      always_ff @(posedge CLK_IN or negedge RESET_N_IN)
      begin
        if (!RESET_N_IN)
        begin
          step <= 32'h0;
          units <= 4'h0;
          armed <= 1'b0;
        end
        else
        begin
          step <= next_step;
          units <= next_units;
          armed <= next_armed;
        end
      end

      assign tmr_armed[g] = armed;
    end
  endgenerate

  // ************************************************************
  // Register set
  // ************************************************************
  logic power_switch_on, next_power_switch_on;
  logic soft_rst, next_soft_rst;
  logic auto_low_power_detect, next_auto;
  logic left_speaker_to_minus_switch, next_speaker;
  logic vendor_test_access, next_test_access;
  logic [3:0] identification_start_delay, next_ident_code;
  logic [3:0] idle_code, next_idle_code;
  logic reset_flag, next_reset_flag;
  logic active_mode, next_active_mode;
  logic low_power_state, next_low_power;
  logic [7:0] test_reg [3];
  logic [7:0] next_test_reg [3];
  logic [1:0] settle, next_settle;
  logic bus_prev, ident_pulse;
  logic idle_run;
  logic [7:0] rd_word;
  logic [1:0] test_idx;

  // Identification delay runs from a bus rising edge while bus stays
  assign tmr_code[0] = identification_start_delay;
  assign tmr_clear[0] = ~bus_s | soft_rst;
  assign tmr_start[0] = bus_s & ~bus_prev;
  // Idle timer runs with auto detect, accessory and no activity
  assign idle_run = auto_low_power_detect & attached_s & ~low_power_state;
  assign tmr_code[1] = idle_code;
  assign tmr_clear[1] = ~idle_run | activity_s | soft_rst;
  assign tmr_start[1] = idle_run & ~tmr_armed[1];
  assign test_idx = 2'(link_req.addr - `ADDR_TEST_FIRST);

  // Read mux; unlisted bits stay zero
  always_comb
  begin
    rd_word = 8'h00;
    case (link_req.addr)
      `ADDR_CTRL:
      begin
        rd_word[`CTRL_SWITCH_BIT] = power_switch_on;
        rd_word[`CTRL_SOFT_RESET_BIT] = soft_rst;
        rd_word[`CTRL_AUTO_BIT] = auto_low_power_detect;
        rd_word[`CTRL_SPEAKER_BIT] = left_speaker_to_minus_switch;
        rd_word[`CTRL_TEST_BIT] = vendor_test_access;
      end
      `ADDR_DELAY: rd_word = {idle_code, identification_start_delay};
      `ADDR_MODE:
      begin
        rd_word[`MODE_FLAG_BIT] = reset_flag;
        rd_word[`MODE_ACTIVE_BIT] = active_mode;
        rd_word[`MODE_LOW_POWER_BIT] = low_power_state;
      end
      `ADDR_STATUS:
      begin
        rd_word[`STATUS_BUS_BIT] = bus_s;
        rd_word[`STATUS_SWITCH_BIT] = sense_s;
      end
      default:
      begin
        if (in_test && vendor_test_access)
        begin
          rd_word = test_reg[test_idx];
        end
      end
    endcase
  end

  // Next register values; soft reset outranks all but the access handshake and read data
  always_comb
  begin
    next_power_switch_on = power_switch_on;
    next_soft_rst = soft_rst;
    next_auto = auto_low_power_detect;
    next_speaker = left_speaker_to_minus_switch;
    next_test_access = vendor_test_access;
    next_ident_code = identification_start_delay;
    next_idle_code = idle_code;
    next_reset_flag = reset_flag;
    next_active_mode = active_mode;
    next_low_power = low_power_state;
    next_test_reg = test_reg;
    next_settle = settle;
    next_tgl_seen = tgl_s2;
    next_ack_toggle = ack_toggle;
    next_rdata = rdata;
    if (access)
    begin
      next_ack_toggle = tgl_s2;
      if (rd)
      begin
        next_rdata = rd_word;
      end
    end
    if (soft_rst)
    begin
      next_soft_rst = 1'b0;
      next_reset_flag = `FLAG_RESET;
      next_power_switch_on = 1'b0;
      next_auto = `CTRL_AUTO_RESET;
      next_speaker = 1'b0;
      next_test_access = 1'b0;
      next_ident_code = `IDENT_CODE_RESET;
      next_idle_code = `IDLE_CODE_RESET;
      next_active_mode = 1'b0;
      next_low_power = 1'b0;
      next_settle = `SETTLE_RESET;
      next_test_reg = '{default: 8'h00};
    end
    else
    begin
      // Load switch bit once the bus-voltage synchroniser has settled
      if (settle != 2'h0)
      begin
        next_settle = settle - 2'h1;
        if (settle == 2'h1)
        begin
          next_power_switch_on = bus_s;
        end
      end
      // Auto detect: idle timeout enters, activity leaves
      if (auto_low_power_detect)
      begin
        if (activity_s)
        begin
          next_low_power = 1'b0;
        end
        else if (tmr_done[1])
        begin
          next_low_power = 1'b1;
        end
      end
      if (wr && link_req.addr == `ADDR_CTRL)
      begin
        next_power_switch_on = link_req.wdata[`CTRL_SWITCH_BIT];
        next_soft_rst = link_req.wdata[`CTRL_SOFT_RESET_BIT];
        next_auto = link_req.wdata[`CTRL_AUTO_BIT];
        next_speaker = link_req.wdata[`CTRL_SPEAKER_BIT];
        next_test_access = link_req.wdata[`CTRL_TEST_BIT];
      end
      if (wr && link_req.addr == `ADDR_DELAY)
      begin
        next_ident_code = link_req.wdata[3:0];
        next_idle_code = link_req.wdata[7:4];
      end
      if (wr && link_req.addr == `ADDR_MODE)
      begin
        next_active_mode = link_req.wdata[`MODE_ACTIVE_BIT];
        if (!auto_low_power_detect)
        begin
          next_low_power = link_req.wdata[`MODE_LOW_POWER_BIT];
        end
      end
      if (wr && in_test && vendor_test_access)
      begin
        next_test_reg[test_idx] = link_req.wdata;
      end
      if (rd && link_req.addr == `ADDR_MODE)
      begin
        next_reset_flag = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      power_switch_on <= 1'b0;
      soft_rst <= 1'b0;
      auto_low_power_detect <= `CTRL_AUTO_RESET;
      left_speaker_to_minus_switch <= 1'b0;
      vendor_test_access <= 1'b0;
      identification_start_delay <= `IDENT_CODE_RESET;
      idle_code <= `IDLE_CODE_RESET;
      reset_flag <= `FLAG_RESET;
      active_mode <= 1'b0;
      low_power_state <= 1'b0;
      test_reg <= '{default: 8'h00};
      settle <= `SETTLE_RESET;
      bus_prev <= 1'b0;
      ident_pulse <= 1'b0;
      tgl_seen <= 1'b0;
      ack_toggle <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      power_switch_on <= next_power_switch_on;
      soft_rst <= next_soft_rst;
      auto_low_power_detect <= next_auto;
      left_speaker_to_minus_switch <= next_speaker;
      vendor_test_access <= next_test_access;
      identification_start_delay <= next_ident_code;
      idle_code <= next_idle_code;
      reset_flag <= next_reset_flag;
      active_mode <= next_active_mode;
      low_power_state <= next_low_power;
      test_reg <= next_test_reg;
      settle <= next_settle;
      bus_prev <= bus_s;
      ident_pulse <= tmr_done[0];
      tgl_seen <= next_tgl_seen;
      ack_toggle <= next_ack_toggle;
      rdata <= next_rdata;
    end
  end

  // Outputs straight from registers
  assign POWER_SWITCH_ON_OUT = power_switch_on;
  assign LEFT_SPEAKER_TO_MINUS_SWITCH_OUT = left_speaker_to_minus_switch;
  assign LOW_POWER_STATE_OUT = low_power_state;
  assign ACTIVE_MODE_OUT = active_mode;
  assign IDENT_START_OUT = ident_pulse;

  // ************************************************************
  // Checks
  // ************************************************************
  logic wr_ctrl, wr_mode;
  assign wr_ctrl = wr && link_req.addr == `ADDR_CTRL;
  assign wr_mode = wr && link_req.addr == `ADDR_MODE;

  switch_follow_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    wr_ctrl && !soft_rst && !link_req.wdata[`CTRL_SOFT_RESET_BIT]
    |=> POWER_SWITCH_ON_OUT == $past(link_req.wdata[`CTRL_SWITCH_BIT]))
    else $error("power switch does not follow control write");

  switch_reload_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    soft_rst |-> ##4 power_switch_on == $past(bus_s))
    else $error("power switch not reloaded from bus voltage");

  soft_reset_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    wr_ctrl && !soft_rst && link_req.wdata[`CTRL_SOFT_RESET_BIT]
    |=> soft_rst ##1 (!soft_rst && reset_flag && auto_low_power_detect))
    else $error("soft reset did not take effect");

  auto_ignore_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    auto_low_power_detect && wr_mode && !low_power_state && !tmr_done[1]
    |=> !low_power_state)
    else $error("host entered power-save under auto detect");

  manual_hold_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !auto_low_power_detect && !wr_mode && !soft_rst
    |=> $stable(low_power_state))
    else $error("power-save changed without host command");

  speaker_follow_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    wr_ctrl && !soft_rst && !link_req.wdata[`CTRL_SOFT_RESET_BIT]
    |=> LEFT_SPEAKER_TO_MINUS_SWITCH_OUT ==
        $past(link_req.wdata[`CTRL_SPEAKER_BIT]))
    else $error("speaker switch does not follow control write");

  test_block_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    rd && in_test && !vendor_test_access |=> rdata == 8'h00)
    else $error("test register read while blocked");

  flag_clear_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    rd && link_req.addr == `ADDR_MODE && !soft_rst
    |=> !reset_flag && rdata[`MODE_FLAG_BIT] == $past(reset_flag))
    else $error("reset flag not cleared by read");

  mode_read_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    rd && link_req.addr == `ADDR_MODE
    |=> rdata[`MODE_LOW_POWER_BIT] == $past(low_power_state) &&
        rdata[7:3] == 5'h00)
    else $error("mode register read mismatch");

endmodule : accessory_switch_control_regs

/* accessory_switch_control_regs_test.sv */
// Purpose: Self-checking bench for the switch control registers.
// Assumes: Step counts shortened to 10 and 20 cycles.
// Notes:   Sense pin follows the switch command one cycle late.
`timescale 1ns/10ps
`include "switch_ctrl_params.svh"

module accessory_switch_control_regs_test;
  logic clk, rst_n, bus, act, att, sense;
  wire logic lclk, sel_n, ldat, dout, doe, sw, spk, lp, actv, idn;
  int fail_count, check_count, cyc, n;
  logic [7:0] q, r;

  accessory_switch_control_regs #(.IDENT_STEP_CYCLES(32'hA),
    .IDLE_STEP_CYCLES(32'h14)) u_accessory_switch_control_regs (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .LINK_CLK_IN(lclk),
    .LINK_SEL_N_IN(sel_n), .LINK_DATA_IN(ldat), .LINK_DATA_OUT(dout),
    .LINK_DATA_OE_OUT(doe), .BUS_VOLTAGE_IN(bus),
    .SWITCH_ACTIVITY_IN(act), .AUDIO_OR_TTY_ATTACHED_IN(att),
    .POWER_SWITCH_SENSE_IN(sense), .POWER_SWITCH_ON_OUT(sw),
    .LEFT_SPEAKER_TO_MINUS_SWITCH_OUT(spk), .LOW_POWER_STATE_OUT(lp),
    .ACTIVE_MODE_OUT(actv), .IDENT_START_OUT(idn));
  host_link_model u_host_link_model (.link_clk_out(lclk),
    .sel_n_out(sel_n), .data_out(ldat), .data_in(doe ? dout : ~ldat));

  // Core clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Sense follows the switch; hang guard well above the run length
  always @(posedge clk)
  begin
    sense <= sw;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  // Cycles from bus rise to the identification start
  function int ident_wait(input logic [3:0] c);
    return (c + 1) * 10;
  endfunction : ident_wait

  task chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [6:0] a, input logic [7:0] d);
    u_host_link_model.frame(1'b0, a, d, q);
    repeat (8) @(posedge clk);
  endtask : wr

  task rd(input logic [6:0] a, input logic [7:0] e);
    u_host_link_model.frame(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask : rd

  task print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // ****
  // Main sequence
  // ****
  initial
  begin
    {rst_n, bus, act, att, sense} = 5'h08;
    {fail_count, check_count, cyc} = 0;
    void'($urandom(32'h404dcb92));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`ADDR_CTRL, 8'h22);
    rd(`ADDR_DELAY, 8'h94);
    rd(`ADDR_MODE, 8'h01);
    rd(`ADDR_MODE, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      r[2] = 1'b0;
      r[5] = 1'b1;
      wr(`ADDR_CTRL, r);
      rd(`ADDR_CTRL, r & 8'hE2);
      chk({spk, sw}, {r[6], r[1]});
      rd(`ADDR_STATUS, {1'b0, r[1], 5'h01, 1'b0});
    end
    r = $urandom;
    wr(`ADDR_DELAY, r);
    rd(`ADDR_DELAY, r);
    bus <= 1'b0;
    repeat (20) @(posedge clk);
    bus <= 1'b1;
    for (n = 0; n < 300 && idn !== 1'b1; n++)
      @(posedge clk);
    chk(n - ident_wait(r[3:0]) inside {[0:5]}, 8'h01);
    $display("control and delay done");
    wr(`ADDR_MODE, 8'h06);
    chk(lp, 8'h00);
    wr(`ADDR_CTRL, 8'h00);
    wr(`ADDR_MODE, 8'h06);
    chk({actv, lp}, 8'h03);
    rd(`ADDR_MODE, 8'h06);
    wr(`ADDR_MODE, 8'h00);
    wr(`ADDR_CTRL, 8'h20);
    wr(`ADDR_DELAY, 8'h00);
    att <= 1'b1;
    repeat (40) @(posedge clk);
    chk(lp, 8'h01);
    act <= 1'b1;
    repeat (8) @(posedge clk);
    chk(lp, 8'h00);
    $display("power save done");
    wr(`ADDR_TEST_FIRST, 8'h5A);
    rd(`ADDR_TEST_FIRST, 8'h00);
    wr(`ADDR_CTRL, 8'h80);
    rd(`ADDR_TEST_FIRST, 8'h00);
    wr(`ADDR_TEST_LAST, 8'hA5);
    rd(`ADDR_TEST_LAST, 8'hA5);
    rd(7'h10, 8'h00);
    wr(`ADDR_CTRL, 8'h04);
    rd(`ADDR_MODE, 8'h01);
    rd(`ADDR_CTRL, 8'h22);
    $display("test access and soft reset done");
    print_verdict();
  end
endmodule : accessory_switch_control_regs_test

/* host_link_model.sv */
// Purpose: Host side of the serial register link.
// Assumes: Link clock runs only inside a frame.
// Notes:   A write frame has 16 edges, a read frame 20.
`timescale 1ns/10ps

module host_link_model
(
  // Link pins
  output logic link_clk_out,
  output logic sel_n_out,
  output logic data_out,
  input wire logic data_in
);
  // Idle link: clock parked low, frame deselected
  initial
  begin
    link_clk_out = 1'b0;
    sel_n_out = 1'b1;
    data_out = 1'b0;
  end

  // ****
  // One frame, data changed while the clock is low
  // ****
  task automatic frame(input logic rd, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic [15:0] sh;
    sh = {rd, a, d};
    q = 8'h00;
    #37 sel_n_out = 1'b0;
    for (int e = 1; e <= (rd ? 20 : 16); e++)
    begin
      // Spare bits toggle so a stale level cannot pass
      data_out = (e <= 8 || !rd) ? sh[16 - e] : ~data_out;
      #80 link_clk_out = 1'b1;
      if (rd && e > 12)
        q = {q[6:0], data_in};
      #80 link_clk_out = 1'b0;
    end
    #80 sel_n_out = 1'b1;
    #160;
  endtask : frame
endmodule : host_link_model

/* serial_reg_link.sv */
// Purpose: Serial register link on the host's link clock.
// Assumes: Frame select and data in are synchronous to link_clk_in.
// Notes:   Hands each access to the core by a toggle handshake.
`timescale 1ns/10ps
`include "switch_ctrl_params.svh"

module serial_reg_link
(
  // Link side
  input wire logic link_clk_in,
  input wire logic reset_n_in,
  input wire logic sel_n_in,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_out,
  // Core side
  output switch_ctrl_pkg::reg_access_t req_out,
  output logic req_toggle_out,
  input wire logic ack_toggle_in,
  input wire logic [7:0] rdata_in
);

  // ************************************************************
  // Frame state
  // ************************************************************
  switch_ctrl_pkg::link_phase_t phase, next_phase;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] addr_byte, next_addr_byte;
  logic next_data_out, next_data_oe;
  logic issue;
  switch_ctrl_pkg::reg_access_t issue_req;
  logic frame_rst_n;
  logic ack_s1, ack_s2;
  logic next_toggle;
  switch_ctrl_pkg::reg_access_t next_req;

  // Clock may stop outside frames, so select ends the frame by reset
  assign frame_rst_n = reset_n_in & ~sel_n_in;

  // Next frame state; first bit is the read flag, then 7 address bits
  always_comb
  begin
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_addr_byte = addr_byte;
    next_data_out = data_out;
    next_data_oe = data_oe_out;
    issue = 1'b0;
    issue_req = '0;
    case (phase)
      switch_ctrl_pkg::LINK_ADDR:
      begin
        next_shift = {shift[6:0], data_in};
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == 4'h7)
        begin
          next_addr_byte = {shift[6:0], data_in};
          next_bit_cnt = 4'h0;
          if (shift[6])
          begin
            issue = 1'b1;
            issue_req.write = 1'b0;
            issue_req.addr = {shift[5:0], data_in};
            next_phase = switch_ctrl_pkg::LINK_TURN;
          end
          else
          begin
            next_phase = switch_ctrl_pkg::LINK_WRITE;
          end
        end
      end
      switch_ctrl_pkg::LINK_WRITE:
      begin
        next_shift = {shift[6:0], data_in};
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == 4'h7)
        begin
          issue = 1'b1;
          issue_req.write = 1'b1;
          issue_req.addr = addr_byte[6:0];
          issue_req.wdata = {shift[6:0], data_in};
          next_phase = switch_ctrl_pkg::LINK_DONE;
        end
      end
      switch_ctrl_pkg::LINK_TURN:
      begin
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == `LINK_TURN_BITS - 4'h1)
        begin
          // Core answer is stable once the ack toggle matches
          if (ack_s2 == req_toggle_out)
          begin
            next_shift = {rdata_in[6:0], 1'b0};
            next_data_out = rdata_in[7];
          end
          else
          begin
            next_shift = 8'h00;
            next_data_out = 1'b0;
          end
          next_data_oe = 1'b1;
          next_bit_cnt = 4'h0;
          next_phase = switch_ctrl_pkg::LINK_READ;
        end
      end
      switch_ctrl_pkg::LINK_READ:
      begin
        next_data_out = shift[7];
        next_shift = {shift[6:0], 1'b0};
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == 4'h7)
        begin
          next_data_out = 1'b0;
          next_data_oe = 1'b0;
          next_phase = switch_ctrl_pkg::LINK_DONE;
        end
      end
      default:
      begin
        next_phase = switch_ctrl_pkg::LINK_DONE;
      end
    endcase
  end

  // Frame registers
  always_ff @(posedge link_clk_in or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      phase <= switch_ctrl_pkg::LINK_ADDR;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      addr_byte <= 8'h00;
      data_out <= 1'b0;
      data_oe_out <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      addr_byte <= next_addr_byte;
      data_out <= next_data_out;
      data_oe_out <= next_data_oe;
    end
  end

  // ************************************************************
  // Handshake toward the core
  // ************************************************************
  // Payload holds still until the next access, so the core samples it
  always_comb
  begin
    next_req = req_out;
    next_toggle = req_toggle_out;
    if (issue)
    begin
      next_req = issue_req;
      next_toggle = ~req_toggle_out;
    end
  end

  // Payload, toggle and ack synchroniser survive frame boundaries
  always_ff @(posedge link_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      req_out <= '0;
      req_toggle_out <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else
    begin
      req_out <= next_req;
      req_toggle_out <= next_toggle;
      ack_s1 <= ack_toggle_in;
      ack_s2 <= ack_s1;
    end
  end

endmodule : serial_reg_link

/* switch_ctrl_params.svh */
// Purpose: Offsets, bit positions, reset values and timing counts
//          for the accessory switch control register set.
// Assumes: 200 MHz core clock.
// Notes:   Offsets are 7-bit link addresses.
`ifndef SWITCH_CTRL_PARAMS_SVH
`define SWITCH_CTRL_PARAMS_SVH

// ************************************************************
// Register addresses
// ************************************************************
`define ADDR_CTRL 7'h02
`define ADDR_DELAY 7'h03
`define ADDR_MODE 7'h04
`define ADDR_STATUS 7'h05
`define ADDR_TEST_FIRST 7'h24
`define ADDR_TEST_LAST 7'h26

// ************************************************************
// Field positions
// ************************************************************
`define CTRL_SWITCH_BIT 1
`define CTRL_SOFT_RESET_BIT 2
`define CTRL_AUTO_BIT 5
`define CTRL_SPEAKER_BIT 6
`define CTRL_TEST_BIT 7
`define MODE_FLAG_BIT 0
`define MODE_ACTIVE_BIT 1
`define MODE_LOW_POWER_BIT 2
`define STATUS_BUS_BIT 1
`define STATUS_SWITCH_BIT 6

// ************************************************************
// Reset values
// ************************************************************
`define CTRL_AUTO_RESET 1'b1
`define IDENT_CODE_RESET 4'h4
`define IDLE_CODE_RESET 4'h9
`define FLAG_RESET 1'b1
`define SETTLE_RESET 2'h3

// ************************************************************
// Timing
// ************************************************************
`define CLK_KHZ 200000
`define IDENT_STEP_MS 100
`define IDLE_STEP_S 1
`define LINK_TURN_BITS 4'h4

`endif

/* switch_ctrl_pkg.sv */
// Purpose: Types shared by the register set and its serial link.
// Assumes: Nothing beyond the params header.
// Notes:   Access request travels from link to core as one struct.
package switch_ctrl_pkg;

  // Register access request captured at the link
  typedef struct packed
  {
    logic write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  // Phase of the serial frame
  typedef enum {LINK_ADDR, LINK_TURN, LINK_READ, LINK_WRITE, LINK_DONE}
    link_phase_t;

endpackage : switch_ctrl_pkg
